//--- rtl/ppmc_regs.sv
/*
 * read-only power-management capability registers: identifier, link
 * to next capability and capabilities word, answered on a simple
 * config read/write port with a registered read data word.
 * assumes the config decoder presents byte offsets relative to the
 * capability item start and a one-cycle read or write strobe.
 */
`timescale 1ns/1ps
// Functional notes
// R1: the first byte of the item reads 01h, marking it as power management.
// R2: the second byte gives the offset of the next capability, zero if last.
// R3: the link reads 00h for the full-speed function and E4h for high speed.
// R4: bits 15..11 flag wake support in D0, D1, D2, D3hot and D3cold.
// R5: bits 15, 14, 12, 9 read one; 13, 11, 10 read one only for high speed.
// R6: bit 10 reads one only when state D2 is supported.
// R7: bit 9 reads one only when state D1 is supported.
// R8: bits 8..6 encode the maximum auxiliary supply current.
// R9: the auxiliary field reads 000b with a data register or no D3cold wake.
// R10: bit 5 flags a device-specific init need and reads zero here.
// R11: bit 3 flags a wake dependence on the bus clock and reads zero here.
// R12: a function with no wake in any state returns zero in bit 3.
// R13: bits 2..0 read 010b for the interface revision supported.
// R14: writes to the link or capabilities word change nothing.
module ppmc_regs
(
    input  wire logic        clk_in,        // bus clock, 25 MHz
    input  wire logic        resetn_in,     // sync reset, active low
    input  wire logic        high_speed_in, // function select strap
    input  wire logic        rd_in,         // read strobe, one cycle
    input  wire logic        wr_in,         // write strobe, one cycle
    input  wire logic [7:0]  addr_in,       // byte offset in the item
    input  wire logic [31:0] wdata_in,      // write data, ignored
    output logic [31:0]      rdata_out,     // read data, registered
    output logic             rvalid_out     // read data valid pulse
);
    import ppmc_pkg::*;

    logic [2:0]  strap_sync_ff;
    logic [2:0]  nxt_strap_sync;
    logic        func_high_ff;
    logic        nxt_func_high;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [15:0] caps_word;
    logic [7:0]  link_byte;
    logic [31:0] item_word;

    // capabilities word for the selected function
    ppmc_caps_word u_caps (
        .high_speed_in (func_high_ff),
        .caps_out      (caps_word)
    );

    // returns the byte lane view of the item for byte offsets 0 to 3, zero past the item
    function automatic logic [31:0] item_read(input logic [7:0] ofs,
                                              input logic [31:0] word);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (ofs[1:0])
            2'h0: r = word;
            2'h1: r = {8'h00, word[31:8]};
            2'h2: r = {16'h0000, word[31:16]};
            2'h3: r = {24'h00_0000, word[31:24]};
        endcase
        if (ofs[7:2] != 6'h00) begin
            r = 32'h0000_0000;
        end
        return r;
    endfunction : item_read

    // strap synchroniser and function select, three stages
    always_comb begin
        nxt_strap_sync = {strap_sync_ff[1:0], high_speed_in};
        nxt_func_high  = func_high_ff;
        if (strap_sync_ff[1] == strap_sync_ff[2]) begin
            nxt_func_high = strap_sync_ff[2];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            strap_sync_ff <= 3'h0;
            func_high_ff  <= 1'b0;
        end else begin
            strap_sync_ff <= nxt_strap_sync;
            func_high_ff  <= nxt_func_high;
        end
    end

    // item layout: id, link, capabilities word
    always_comb begin
        link_byte = func_high_ff ? PPMC_LINK_HIGH
                                 : PPMC_LINK_FULL;        // [R2] [R3]
        item_word = {caps_word, link_byte, PPMC_CAPABILITY_IDENTIFIER};  // [R1]
    end

    // read path; writes have no effect on any bit
    always_comb begin
        nxt_rvalid = rd_in;
        nxt_rdata  = rdata_ff;
        if (rd_in) begin
            nxt_rdata = item_read(addr_in, item_word);
        end
        // wr_in and wdata_in are ignored: every bit is read-only [R14]
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rdata_ff  <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign rdata_out  = rdata_ff;
    assign rvalid_out = rvalid_ff;

    // checks, all on the bus clock, idle while reset is low;
    // the answer reflects the function select of the taking edge,
    // so expectations use the select one cycle back

    // identifier in the low lane of offset 0
    a_id_byte_read: assert property ( // [R1]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_ID |=> rdata_out[7:0] == 8'h01)
        else $error("identifier byte wrong");

    // link value follows the function select
    a_link_value: assert property ( // [R3]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_LINK
        |=> rdata_out[7:0] == ($past(func_high_ff) ? 8'he4 : 8'h00))
        else $error("link byte wrong");

    // the full-speed function is the last item of its list
    a_link_last: assert property ( // [R2]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_LINK && !func_high_ff
        |=> rdata_out[7:0] == 8'h00)
        else $error("last item link not zero");

    // link also shows in the second lane of offset 0
    a_lane_link: assert property ( // [R3]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_ID
        |=> rdata_out[15:8] == ($past(func_high_ff) ? 8'he4 : 8'h00))
        else $error("link lane of offset zero wrong");

    // bits that read one for both functions
    a_caps_fixed: assert property ( // [R5]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_CAPS |=> rdata_out[15] && rdata_out[14]
        && rdata_out[12] && rdata_out[9])
        else $error("fixed caps bits wrong");

    // wake bits for D2 and D0 set only for the high-speed function
    a_caps_speed: assert property ( // [R4] [R5]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_CAPS
        |=> rdata_out[13] == $past(func_high_ff)
        && rdata_out[11] == $past(func_high_ff))
        else $error("wake bits do not follow function");

    // D2 support only for the high-speed function
    a_caps_d2: assert property ( // [R6]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_CAPS
        |=> rdata_out[10] == $past(func_high_ff))
        else $error("d2 support bit wrong");

    // D1 is supported by both functions
    a_caps_d1: assert property ( // [R7]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_CAPS |=> rdata_out[9])
        else $error("d1 support bit wrong");

    // aux current code only with D3cold wake and no data register
    a_caps_aux: assert property ( // [R8] [R9]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_CAPS
        |=> rdata_out[8:6] == (rdata_out[15] ? 3'h2 : 3'h0))
        else $error("aux current field wrong");

    // low six bits of the word: init, reserved, clock and version
    a_caps_low: assert property ( // [R10] [R11] [R12] [R13]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_CAPS
        |=> rdata_out[5:0] == 6'h02)
        else $error("low caps bits wrong");

    // interface revision field
    a_caps_version: assert property ( // [R13]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_CAPS |=> rdata_out[2:0] == 3'h2)
        else $error("version field wrong");

    // no device-specific init sequence is needed
    a_caps_init: assert property ( // [R10]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_CAPS |=> !rdata_out[5])
        else $error("init bit set");

    // wake never depends on the bus clock
    a_caps_clock: assert property ( // [R11] [R12]
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in == PPMC_OFS_CAPS |=> !rdata_out[3])
        else $error("wake clock bit set");

    // offsets past the item read as zero
    a_range_zero: assert property (
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in && addr_in[7:2] != 6'h00 |=> rdata_out == 32'h0000_0000)
        else $error("offset outside item not zero");

    // a write alone changes neither data nor valid
    a_write_inert: assert property ( // [R14]
        @(posedge clk_in) disable iff (!resetn_in)
        wr_in && !rd_in |=> $stable(rdata_out) && !rvalid_out)
        else $error("write disturbed read data");

    // valid answers one edge after each read
    a_valid_pulse: assert property (
        @(posedge clk_in) disable iff (!resetn_in)
        rd_in |=> rvalid_out ##1 (rvalid_out == $past(rd_in)))
        else $error("read valid timing wrong");

    // no valid without a read
    a_valid_idle: assert property (
        @(posedge clk_in) disable iff (!resetn_in)
        !rd_in |=> !rvalid_out)
        else $error("valid without read");

    // function select moves only once two sync stages agree
    a_strap_settle: assert property (
        @(posedge clk_in) disable iff (!resetn_in)
        $changed(func_high_ff)
        |-> $past(strap_sync_ff[1]) == $past(strap_sync_ff[2])
        && func_high_ff == $past(strap_sync_ff[2]))
        else $error("function select moved unsettled");
endmodule : ppmc_regs

//--- rtl/ppmc_pkg.sv
/*
 * constants for the power-management capability registers: offsets
 * within the capability item, field positions and the fixed values for
 * the two host functions.
 * assumes the capability item starts at config offset 34h, PPMC_ITEM_BASE.
 */
package ppmc_pkg;
    // byte offsets relative to the start of the capability item, then the item's config offset
    localparam logic [7:0] PPMC_OFS_ID         = 8'h00;
    localparam logic [7:0] PPMC_OFS_LINK       = 8'h01;
    localparam logic [7:0] PPMC_OFS_CAPS       = 8'h02;
    localparam logic [7:0] PPMC_ITEM_BASE      = 8'h34;
    // fixed values
    localparam logic [7:0] PPMC_CAPABILITY_IDENTIFIER         = 8'h01;
    localparam logic [7:0] PPMC_LINK_FULL      = 8'h00;
    localparam logic [7:0] PPMC_LINK_HIGH      = 8'he4;
    localparam logic [2:0] PPMC_SPEC_VERSION   = 3'h2;
    localparam logic [2:0] PPMC_AUX_CURRENT    = 3'h2;
    localparam logic       PPMC_DATA_REG_IMPL  = 1'b0;
    localparam logic       PPMC_INIT_NEEDED    = 1'b0;
    localparam logic       PPMC_WAKE_CLK       = 1'b0;
    // field positions in the capabilities word
    localparam int PPMC_WAKE_LSB   = 11;
    localparam int PPMC_WAKE_MSB   = 15;
    localparam int PPMC_D2_BIT     = 10;
    localparam int PPMC_D1_BIT     = 9;
    localparam int PPMC_AUX_LSB    = 6;
    localparam int PPMC_AUX_MSB    = 8;
    localparam int PPMC_INIT_BIT   = 5;
    localparam int PPMC_CLK_BIT    = 3;
    localparam int PPMC_VER_LSB    = 0;
    localparam int PPMC_VER_MSB    = 2;
    // wake support per state, bit0 = D0 .. bit4 = D3cold
    localparam logic [4:0] PPMC_WAKE_FULL      = 5'h1a;
    localparam logic [4:0] PPMC_WAKE_HIGH      = 5'h1f;
endpackage : ppmc_pkg

//--- rtl/ppmc_caps_word.sv
/*
 * builds the constant capabilities word for one host function.
 * assumes the function select input is stable (a strap level).
 */
`timescale 1ns/1ps
module ppmc_caps_word
    import ppmc_pkg::*;
(
    input  wire logic        high_speed_in, // 1 = high-speed function
    output logic [15:0]      caps_out       // capabilities word
);
    logic [4:0] wake_state_support;
    logic       state_two_supported;
    logic       state_one_supported;
    logic [2:0] aux_field;

    // per-function fields
    always_comb begin
        wake_state_support  = high_speed_in ? PPMC_WAKE_HIGH
                                            : PPMC_WAKE_FULL;     // [R4] [R5]
        state_two_supported = high_speed_in;                      // [R6]
        state_one_supported = 1'b1;                               // [R7]
        // no aux current when data reg exists or no D3cold wake
        if (PPMC_DATA_REG_IMPL || !wake_state_support[4]) begin
            aux_field = 3'h0;                                     // [R9]
        end else begin
            aux_field = PPMC_AUX_CURRENT;                         // [R8]
        end
    end

    // pack the word
    always_comb begin
        caps_out = 16'h0000;
        caps_out[PPMC_WAKE_MSB:PPMC_WAKE_LSB] = wake_state_support;
        caps_out[PPMC_D2_BIT]   = state_two_supported;
        caps_out[PPMC_D1_BIT]   = state_one_supported;
        caps_out[PPMC_AUX_MSB:PPMC_AUX_LSB] = aux_field;
        caps_out[PPMC_INIT_BIT] = PPMC_INIT_NEEDED;               // [R10]
        // clock bit only when some wake state is possible
        caps_out[PPMC_CLK_BIT]  = (|wake_state_support) ?
                                  PPMC_WAKE_CLK : 1'b0;           // [R11] [R12]
        caps_out[PPMC_VER_MSB:PPMC_VER_LSB] = PPMC_SPEC_VERSION;  // [R13]
    end
endmodule : ppmc_caps_word

//--- bench/ppmc_host.sv
/*
 * config host model: one read or write request per call, placed at
 * the next rising edge by non-blocking assignment.
 * assumes the caller lets each call return before the next one.
 */
`timescale 1ns/1ps
module ppmc_host (
    input  wire logic        clk_in,    // bus clock
    output logic             rd_out,    // read strobe
    output logic             wr_out,    // write strobe
    output logic [7:0]       addr_out,  // byte offset in the item
    output logic [31:0]      wdata_out  // write data
);
    // quiet lines at time zero
    initial begin
        rd_out    = 1'b0;
        wr_out    = 1'b0;
        addr_out  = 8'h00;
        wdata_out = 32'h0;
    end
    // idle cycles flip address and data so stale values never match
    task automatic issue(input logic r, input logic w,
                         input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        rd_out    <= r;
        wr_out    <= w;
        addr_out  <= (r | w) ? a : ~addr_out;
        wdata_out <= w ? d : ~wdata_out;
    endtask : issue
endmodule : ppmc_host

//--- bench/ppmc_regs_tb_top.sv
/*
 * self-checking bench for the capability registers: table of reads
 * for both host functions, then writes and back-to-back reads.
 * assumes the read answer lands one edge after the taking edge.
 */
`timescale 1ns/1ps
module ppmc_regs_tb_top;
    import ppmc_pkg::*;
    typedef struct packed {
        logic        hs;
        logic [7:0]  a;
        logic [31:0] d;
    } ppmc_row_type;
    logic        clk_in        = 1'b0;
    logic        resetn_in     = 1'b0;
    logic        high_speed_in = 1'b0;
    logic        rd_in;
    logic        wr_in;
    logic [7:0]  addr_in;
    logic [31:0] wdata_in;
    logic [31:0] rdata_out;
    logic        rvalid_out;
    int          num_errors      = 0;
    int          samples_checked = 0;
    // full caps d282, high caps fe82, aux code 010b, version 010b
    ppmc_row_type rows [9] = '{
        {1'b0, 8'h00, 32'hd2820001}, {1'b0, 8'h01, 32'h00d28200},
        {1'b0, 8'h02, 32'h0000d282}, {1'b0, 8'h03, 32'h000000d2},
        {1'b0, 8'h04, 32'h00000000}, {1'b1, 8'h00, 32'hfe82e401},
        {1'b1, 8'h01, 32'h00fe82e4}, {1'b1, 8'h03, 32'h000000fe},
        {1'b1, 8'h02, 32'h0000fe82}};
    ppmc_host host_u (.clk_in(clk_in), .rd_out(rd_in), .wr_out(wr_in),
        .addr_out(addr_in), .wdata_out(wdata_in));
    ppmc_regs dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
        .high_speed_in(high_speed_in), .rd_in(rd_in), .wr_in(wr_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .rvalid_out(rvalid_out));
    // 25 MHz clock
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // answer after the taking edge: valid pulse with the data
    task automatic look(input logic [31:0] exp, input logic v);
        #1;
        check({31'h0, rvalid_out}, {31'h0, v});
        check(rdata_out, exp);
    endtask : look
    // reset with a strap level; outputs cleared meanwhile
    task automatic do_reset(input logic hs, input int n);
        @(posedge clk_in);
        resetn_in     <= 1'b0;
        high_speed_in <= hs;
        repeat (n) @(posedge clk_in);
        look(32'h0, 1'b0);
        @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        $display("test reset done");
    endtask : do_reset
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    // stop a hang
    initial begin
        #(40 * 4000);
        num_errors++;
        $display("test watchdog expired");
        end_of_test();
    end
    // main sequence
    initial begin
        do_reset(1'b0, 12);
        for (int i = 0; i < 9; i++) begin
            if (rows[i].hs !== high_speed_in) begin
                do_reset(rows[i].hs, 2);
            end
            host_u.issue(1'b1, 1'b0, rows[i].a, 32'h0);
            host_u.issue(1'b0, 1'b0, 8'h00, 32'h0);
            look(rows[i].d, 1'b1); // row
            host_u.issue(1'b0, 1'b0, 8'h00, 32'h0);
            look(rows[i].d, 1'b0); // held
        end
        $display("test table done");
        // idle: data held, no pulse
        host_u.issue(1'b0, 1'b0, 8'h00, 32'h0);
        look(32'h0000fe82, 1'b0);
        $display("test hold done");
        // writes to link and caps, then two reads back to back
        host_u.issue(1'b0, 1'b1, 8'h01, 32'hffffffff);
        host_u.issue(1'b0, 1'b1, 8'h02, 32'h00000000);
        look(32'h0000fe82, 1'b0); // write refused
        host_u.issue(1'b1, 1'b0, 8'h00, 32'h0);
        host_u.issue(1'b1, 1'b0, 8'h02, 32'h0);
        look(32'hfe82e401, 1'b1); // link unchanged
        host_u.issue(1'b0, 1'b0, 8'h00, 32'h0);
        look(32'h0000fe82, 1'b1); // caps unchanged
        $display("test writes done");
        end_of_test();
    end
endmodule : ppmc_regs_tb_top
